// file: design/ftc_control_words.sv
// Purpose: Serial command receiver and the format and test control words.
// Assumes: Serial pins come from the host asynchronously; datapath is on clk_sys.
// Notes:   A command is accepted when the frame closes after exactly 40 bits.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Q drive field: off, on, or slot-only
// - Input format bit: offset binary or two's complement
// - Address 111 routes command to test word
// - Update bit only pulses update_all; a write goes active at once without it
// - Input test bit forces samples to 8000 hex
// - FIR mode 00 clears accumulator each computation
// - FIR mode 01 disables the accumulator
// - FIR mode 10 never clears; 11 reserved
// - Rollover bit pulses Q on phase wrap
// - Force bit drives outputs to static levels
// - Forced clock bit drives the output clock
// - Test word acts only while test enabled
// - Address and update bits are never stored
module ftc_control_words
  import ftc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ser_clk,
  input  wire logic                ser_data,
  input  wire logic                ser_frame_n,
  input  wire logic                test_enable,
  input  wire logic [2:0]          readback_sel,
  output logic      [DATA_W-1:0]   readback_data,
  output logic                     update_all,
  input  wire logic [SAMPLE_W-1:0] sample_in,
  output logic      [SAMPLE_W-1:0] sample_out,
  input  wire logic                fir_start,
  output logic                     fir_acc_clear,
  output logic                     fir_acc_enable,
  input  wire logic                phase_rollover,
  input  wire logic                time_slot_active,
  input  wire logic                q_normal,
  input  wire logic                i_normal,
  input  wire logic                strobe_normal,
  output logic                     q_o,
  output logic                     q_oe,
  output logic                     i_o,
  output logic                     strobe_o,
  output logic                     serial_output_clock
);

  // Pin synchronisers; only the second stage feeds logic.
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       s_clk_d;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync_a  <= 3'h7;
      sync_b  <= 3'h7;
      s_clk_d <= 1'b1;
    end
    else
    begin
      sync_a  <= {ser_frame_n, ser_data, ser_clk};
      sync_b  <= sync_a;
      s_clk_d <= sync_b[0];
    end
  end

  wire s_clk     = sync_b[0];
  wire s_data    = sync_b[1];
  wire s_frame_n = sync_b[2];
  wire clk_rise  = s_clk & ~s_clk_d;

  // Serial receiver.
  ftc_rx_t          rx_state;
  logic [CMD_W-1:0] shift;
  logic [CNT_W-1:0] bit_cnt;

  wire     in_frame   = ~s_frame_n;
  wire     take_bit   = (rx_state == FTC_RX_SHIFT) && in_frame && clk_rise;
  wire     frame_done = (rx_state == FTC_RX_SHIFT) && !in_frame;
  // Short or long frames are dropped whole so a glitch cannot corrupt a word.
  wire     cmd_valid  = frame_done && (bit_cnt == CMD_BITS);
  ftc_rx_t next_rx_state;

  always_comb
  begin
    next_rx_state = rx_state;
    unique case (rx_state)
      FTC_RX_IDLE:
      begin
        if (in_frame)
        begin
          next_rx_state = FTC_RX_SHIFT;
        end
      end
      FTC_RX_SHIFT:
      begin
        if (!in_frame)
        begin
          next_rx_state = FTC_RX_IDLE;
        end
      end
    endcase
  end

  wire [CNT_W-1:0] next_bit_cnt = (rx_state == FTC_RX_IDLE) ? '0 :
                                  (take_bit && bit_cnt != '1) ? bit_cnt + 1'b1 : bit_cnt;
  wire [CMD_W-1:0] next_shift   = take_bit ? {shift[CMD_W-2:0], s_data} : shift;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rx_state <= FTC_RX_IDLE;
      bit_cnt  <= '0;
      shift    <= '0;
    end
    else
    begin
      rx_state <= next_rx_state;
      bit_cnt  <= next_bit_cnt;
      shift    <= next_shift;
    end
  end

  // Routing; only the 36 payload bits are kept.
  wire [2:0]        cmd_addr    = shift[ADDR_HI:ADDR_LO];
  wire              cmd_update  = shift[UPDATE_BIT];
  wire [DATA_W-1:0] cmd_payload = shift[DATA_W-1:0];
  wire              hit_fmt     = cmd_valid && (cmd_addr == ADDR_IO_FORMAT);
  wire              hit_test    = cmd_valid && (cmd_addr == ADDR_TEST);
  wire              commit_all  = cmd_valid && cmd_update;

  logic [DATA_W-1:0] pend_fmt;
  logic [DATA_W-1:0] pend_test;
  logic [DATA_W-1:0] act_fmt;
  logic [DATA_W-1:0] act_test;

  wire [DATA_W-1:0] next_pend_fmt  = hit_fmt ? cmd_payload : pend_fmt;
  wire [DATA_W-1:0] next_pend_test = hit_test ? cmd_payload : pend_test;
  wire [DATA_W-1:0] next_act_fmt   = hit_fmt ? cmd_payload :
                                     commit_all ? pend_fmt : act_fmt;
  wire [DATA_W-1:0] next_act_test  = hit_test ? cmd_payload :
                                     commit_all ? pend_test : act_test;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pend_fmt   <= IO_FORMAT_RESET;
      pend_test  <= TEST_RESET;
      act_fmt    <= IO_FORMAT_RESET;
      act_test   <= TEST_RESET;
      update_all <= 1'b0;
    end
    else
    begin
      pend_fmt   <= next_pend_fmt;
      pend_test  <= next_pend_test;
      act_fmt    <= next_act_fmt;
      act_test   <= next_act_test;
      update_all <= commit_all;
    end
  end

  // Readback shows the active payload; routing bits are gone by design.
  wire [DATA_W-1:0] next_readback = (readback_sel == ADDR_IO_FORMAT) ? act_fmt :
                                    (readback_sel == ADDR_TEST) ? act_test : '0;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      readback_data <= '0;
    end
    else
    begin
      readback_data <= next_readback;
    end
  end

  // Field views.
  ftc_io_fmt_t fmt;
  ftc_test_t   tst;

  assign fmt.q_drive   = ftc_q_drive_t'(act_fmt[Q_DRIVE_HI:Q_DRIVE_LO]);
  assign fmt.twos_comp = act_fmt[IN_FMT_BIT];
  assign fmt.preload   = act_fmt[PRELOAD_HI:PRELOAD_LO];

  // The whole test word is masked off unless test features are enabled.
  wire [DATA_W-1:0] eff_test = test_enable ? act_test : '0;

  assign tst.force_in  = eff_test[FORCE_IN_BIT];
  assign tst.fir_mode  = ftc_fir_mode_t'(eff_test[FIR_HI:FIR_LO]);
  assign tst.rollover  = eff_test[ROLLOVER_BIT];
  assign tst.force_out = eff_test[FORCE_OUT_BIT];
  assign tst.f_clk     = eff_test[F_CLK_BIT];
  assign tst.f_stb     = eff_test[F_STB_BIT];
  assign tst.f_i       = eff_test[F_I_BIT];
  assign tst.f_q       = eff_test[F_Q_BIT];

  // Input samples are normalised to two's complement for the mixer.
  wire [SAMPLE_W-1:0] conv_sample = fmt.twos_comp ? sample_in :
                                    sample_in ^ SIGN_FLIP;
  wire [SAMPLE_W-1:0] next_sample = tst.force_in ? FORCED_SAMPLE : conv_sample;

  // FIR accumulator steering; reserved code falls back to normal behaviour.
  logic next_acc_clear;
  logic next_acc_enable;

  always_comb
  begin
    next_acc_clear  = fir_start;
    next_acc_enable = 1'b1;
    unique case (tst.fir_mode)
      FTC_FIR_NORMAL: next_acc_clear = fir_start;
      FTC_FIR_NONE:
      begin
        next_acc_clear  = 1'b0;
        next_acc_enable = 1'b0;
      end
      FTC_FIR_CONT:   next_acc_clear = 1'b0;
      FTC_FIR_RSVD:   next_acc_clear = fir_start;
    endcase
  end

  // Bit clock toggles on every rate counter terminal count.
  logic rate_tick;
  logic bit_clk;

  ftc_rate_counter #(
    .WIDTH (PRELOAD_W)
  ) u_rate (
    .clk_sys (clk_sys),
    .rst     (rst),
    .preload (fmt.preload),
    .tick    (rate_tick)
  );

  wire next_bit_clk = rate_tick ? ~bit_clk : bit_clk;

  // Q drive; the upper bit alone selects slot-only drive.
  wire next_q_oe = (fmt.q_drive == FTC_QD_ON) ||
                   (fmt.q_drive[1] && time_slot_active);

  // Rollover strobes replace Q data; forcing then overrides everything.
  wire q_pre       = tst.rollover ? phase_rollover : q_normal;
  wire next_q      = tst.force_out ? tst.f_q : q_pre;
  wire next_i      = tst.force_out ? tst.f_i : i_normal;
  wire next_strobe = tst.force_out ? tst.f_stb : strobe_normal;
  wire next_oclk   = tst.force_out ? tst.f_clk : next_bit_clk;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sample_out          <= '0;
      fir_acc_clear       <= 1'b0;
      fir_acc_enable      <= 1'b1;
      bit_clk             <= 1'b0;
      q_oe                <= 1'b0;
      q_o                 <= 1'b0;
      i_o                 <= 1'b0;
      strobe_o            <= 1'b0;
      serial_output_clock <= 1'b0;
    end
    else
    begin
      sample_out          <= next_sample;
      fir_acc_clear       <= next_acc_clear;
      fir_acc_enable      <= next_acc_enable;
      bit_clk             <= next_bit_clk;
      q_oe                <= next_q_oe;
      q_o                 <= next_q;
      i_o                 <= next_i;
      strobe_o            <= next_strobe;
      serial_output_clock <= next_oclk;
    end
  end

endmodule
`default_nettype wire

// file: include/ftc_pkg.sv
// Purpose: Shared constants and types for the format and test control words.
// Assumes: 40-bit serial commands, address in the top three bits, MSB first.
// Notes:   Reset values of both words are all zero except a legal preload.
package ftc_pkg;

  localparam int CMD_W      = 40;
  localparam int DATA_W     = 36;
  localparam int CNT_W      = 6;
  localparam int ADDR_HI    = 39;
  localparam int ADDR_LO    = 37;
  localparam int UPDATE_BIT = 36;
  localparam logic [CNT_W-1:0] CMD_BITS = 6'h28;

  localparam logic [2:0] ADDR_IO_FORMAT = 3'h6;
  localparam logic [2:0] ADDR_TEST      = 3'h7;

  // Format word fields.
  localparam int Q_DRIVE_HI = 15;
  localparam int Q_DRIVE_LO = 14;
  localparam int IN_FMT_BIT = 13;
  localparam int PRELOAD_HI = 12;
  localparam int PRELOAD_LO = 0;
  localparam int PRELOAD_W  = 13;
  localparam logic [PRELOAD_W-1:0] PRELOAD_MIN = 13'h0002;
  localparam logic [PRELOAD_W-1:0] PRELOAD_MAX = 13'h06A5;

  // Test word fields.
  localparam int FORCE_IN_BIT  = 13;
  localparam int FIR_HI        = 12;
  localparam int FIR_LO        = 11;
  localparam int ROLLOVER_BIT  = 10;
  localparam int FORCE_OUT_BIT = 9;
  localparam int F_CLK_BIT     = 8;
  localparam int F_STB_BIT     = 7;
  localparam int F_I_BIT       = 6;
  localparam int F_Q_BIT       = 5;

  localparam logic [DATA_W-1:0] IO_FORMAT_RESET = 36'h000000002;
  localparam logic [DATA_W-1:0] TEST_RESET      = 36'h000000000;

  localparam int SAMPLE_W = 16;
  localparam logic [SAMPLE_W-1:0] FORCED_SAMPLE = 16'h8000;
  localparam logic [SAMPLE_W-1:0] SIGN_FLIP     = 16'h8000;

  typedef enum logic [1:0]
  {
    FTC_QD_OFF    = 2'b00,
    FTC_QD_ON     = 2'b01,
    FTC_QD_SLOT   = 2'b10,
    FTC_QD_SLOT_B = 2'b11
  } ftc_q_drive_t;

  typedef enum logic [1:0]
  {
    FTC_FIR_NORMAL = 2'b00,
    FTC_FIR_NONE   = 2'b01,
    FTC_FIR_CONT   = 2'b10,
    FTC_FIR_RSVD   = 2'b11
  } ftc_fir_mode_t;

  typedef enum logic
  {
    FTC_RX_IDLE  = 1'b0,
    FTC_RX_SHIFT = 1'b1
  } ftc_rx_t;

  typedef struct packed
  {
    ftc_q_drive_t         q_drive;
    logic                 twos_comp;
    logic [PRELOAD_W-1:0] preload;
  } ftc_io_fmt_t;

  typedef struct packed
  {
    logic          force_in;
    ftc_fir_mode_t fir_mode;
    logic          rollover;
    logic          force_out;
    logic          f_clk;
    logic          f_stb;
    logic          f_i;
    logic          f_q;
  } ftc_test_t;

endpackage

// file: design/ftc_rate_counter.sv
// Purpose: Output clock rate counter that reloads from the preload field.
// Assumes: Preload is held in the legal range by the host.
// Notes:   One tick per terminal count; the tick sets the bit clock rate.
`timescale 1ns/1ns
`default_nettype none
module ftc_rate_counter
  import ftc_pkg::*;
#(
  parameter int WIDTH = PRELOAD_W
)
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] preload,
  output logic                  tick
);

  logic [WIDTH-1:0] count;
  wire              terminal = (count == '0);
  wire  [WIDTH-1:0] next_count = terminal ? preload : count - 1'b1;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      count <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick  <= terminal;
    end
  end

endmodule
`default_nettype wire

// file: testbench/ftc_chk.sv
// Purpose: Port checks for the format and test control words.
// Assumes: Readback shows the word that drove the outputs on the same edge.
// Notes: Word-dependent checks pair readback with the registered select, so it need not be held.
`timescale 1ns/1ns
`default_nettype none
module ftc_chk
  import ftc_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        test_enable,
  input wire logic [2:0]  readback_sel,
  input wire logic [35:0] readback_data,
  input wire logic [15:0] sample_in,
  input wire logic [15:0] sample_out,
  input wire logic        fir_start,
  input wire logic        fir_acc_clear,
  input wire logic        fir_acc_enable,
  input wire logic        phase_rollover,
  input wire logic        time_slot_active,
  input wire logic        q_normal,
  input wire logic        q_o,
  input wire logic        q_oe,
  input wire logic        i_o,
  input wire logic        strobe_o,
  input wire logic        serial_output_clock
);
  logic       live;
  logic       te_q;
  logic [2:0] sel_q;
  wire        fmt_on = sel_q == ADDR_IO_FORMAT;
  wire        tst_on = te_q && sel_q == ADDR_TEST;
  wire [35:0] rd = readback_data;
  always_ff @(posedge clk_sys)
  begin
    live  <= !rst;
    te_q  <= test_enable;
    sel_q <= readback_sel;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst || !live);
  // Forcing may start inside a hold window, so forced cycles are let through.
  // Leaving forcing is no bit clock edge, so both sides of an edge must be unforced.
  sequence s_edge;
    !te_q && !$past(te_q) && $changed(serial_output_clock);
  endsequence
  sequence s_hold;
    ($stable(serial_output_clock) || te_q)[*2];
  endsequence
  a_qoe_drive: assert property (
    fmt_on |-> q_oe == (rd[15:14] == 2'b01 || (rd[15] && $past(time_slot_active))))
    else $error("Q enable wrong");
  a_in_format: assert property (
    fmt_on && !te_q |-> sample_out ==
      (rd[13] ? $past(sample_in) : $past(sample_in) ^ SIGN_FLIP))
    else $error("sample format wrong");
  a_force_sample: assert property (
    tst_on && rd[13] |-> sample_out == FORCED_SAMPLE)
    else $error("sample not forced");
  a_fir_enable: assert property (
    tst_on |-> fir_acc_enable == (rd[12:11] != 2'b01))
    else $error("accumulator enable wrong");
  a_fir_clear: assert property (
    tst_on |-> fir_acc_clear == ($past(fir_start) && rd[12] == rd[11]))
    else $error("accumulator clear wrong");
  a_rollover_q: assert property (
    tst_on && rd[10] && !rd[9] |-> q_o == $past(phase_rollover))
    else $error("Q does not follow rollover");
  a_force_pins: assert property (
    tst_on && rd[9] |-> {serial_output_clock, strobe_o, i_o, q_o} == rd[8:5])
    else $error("forced levels wrong");
  a_test_off: assert property (
    !te_q |-> q_o == $past(q_normal) && fir_acc_enable && fir_acc_clear == $past(fir_start))
    else $error("test word acts while disabled");
  a_rb_other: assert property (
    sel_q != ADDR_IO_FORMAT && sel_q != ADDR_TEST |-> readback_data == '0)
    else $error("unmapped readback not zero");
  a_clk_hold: assert property (
    s_edge |=> s_hold)
    else $error("output clock period too short");
endmodule
bind ftc_control_words ftc_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .test_enable(test_enable), .readback_sel(readback_sel), .readback_data(readback_data),
  .sample_in(sample_in), .sample_out(sample_out), .fir_start(fir_start),
  .fir_acc_clear(fir_acc_clear), .fir_acc_enable(fir_acc_enable),
  .phase_rollover(phase_rollover), .time_slot_active(time_slot_active),
  .q_normal(q_normal), .q_o(q_o), .q_oe(q_oe), .i_o(i_o), .strobe_o(strobe_o),
  .serial_output_clock(serial_output_clock));
`default_nettype wire

// file: testbench/ftc_host.sv
// Purpose: Host serial port that sends 40-bit control commands.
// Assumes: Each serial clock phase lasts four system cycles.
// Notes: Data is inverted when the frame closes so a stale bit never looks valid.
`timescale 1ns/1ns
`default_nettype none
module ftc_host
(
  input  wire logic clk_sys,
  output var logic  ser_clk,
  output var logic  ser_data,
  output var logic  ser_frame_n
);
  initial
  begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_frame_n = 1'b1;
  end
  // Callers pick factors that keep the result between 2 and 1701.
  function automatic int preload_for(input int high_decimation_filter, input int time_slot_length);
    return (high_decimation_filter * 4) / time_slot_length - 1;
  endfunction
  task automatic send(input logic [39:0] cmd, input int nbits);
    ser_frame_n = 1'b0;
    for (int i = 39; i > 39 - nbits; i--)
    begin
      ser_data = cmd[i];
      repeat (4) @(negedge clk_sys);
      ser_clk = 1'b1;
      repeat (4) @(negedge clk_sys);
      ser_clk = 1'b0;
    end
    ser_frame_n = 1'b1;
    ser_data = ~ser_data;
  endtask
endmodule
`default_nettype wire

// file: testbench/ftc_control_words_tb.sv
// Purpose: Self-checking bench for the format and test control words.
// Assumes: Outputs and readback settle one cycle after their inputs.
// Notes: The host never sets reserved test bits or FIR code 11.
`timescale 1ns/1ns
`default_nettype none
module ftc_control_words_tb
  import ftc_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst, te, fs, ph, slot, qn, inn, sn, soc, upd, qo, qoe, io, so, fe, fc;
  logic [2:0]  sel;
  logic [15:0] si, sout;
  logic [35:0] rb, fmt, tst;
  wire         sck, sd, sfn;
  int          num_errors = 0;
  int          n_tests = 0;
  always #5 clk_sys = ~clk_sys;
  ftc_host host (.clk_sys(clk_sys), .ser_clk(sck), .ser_data(sd), .ser_frame_n(sfn));
  ftc_control_words DUT (.clk_sys(clk_sys), .rst(rst), .ser_clk(sck), .ser_data(sd),
    .ser_frame_n(sfn), .test_enable(te), .readback_sel(sel), .readback_data(rb),
    .update_all(upd), .sample_in(si), .sample_out(sout), .fir_start(fs),
    .fir_acc_clear(fc), .fir_acc_enable(fe), .phase_rollover(ph), .time_slot_active(slot),
    .q_normal(qn), .i_normal(inn), .strobe_normal(sn), .q_o(qo), .q_oe(qoe), .i_o(io),
    .strobe_o(so), .serial_output_clock(soc));
  task automatic stop_test();
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [2:0] a, input logic u, input logic [35:0] d);
    logic seen;
    seen = 1'b0;
    host.send({a, u, d}, 40);
    repeat (12)
    begin
      @(negedge clk_sys);
      seen |= upd;
    end
    chk({35'h0, seen}, {35'h0, u});
    if (a == ADDR_IO_FORMAT)
      fmt = d;
    if (a == ADDR_TEST)
      tst = d;
  endtask
  task automatic dp(input logic [2:0] s);
    logic t;
    logic [21:0] e;
    sel = s;
    {si, qn, inn, sn, ph, slot, fs} = 22'($urandom);
    t = te;
    @(negedge clk_sys);
    e[21] = fmt[15:14] == 2'b01 || (fmt[15] && slot);
    e[20] = t && tst[9] ? tst[5] : (t && tst[10] ? ph : qn);
    e[19] = t && tst[9] ? tst[6] : inn;
    e[18] = t && tst[9] ? tst[7] : sn;
    e[17] = !(t && tst[12:11] == 2'b01);
    e[16] = fs && !(t && tst[12] != tst[11]);
    e[15:0] = t && tst[13] ? FORCED_SAMPLE : (fmt[13] ? si : si ^ SIGN_FLIP);
    chk({14'h0, qoe, qo, io, so, fe, fc, sout}, {14'h0, e});
    chk(rb, s == 3'h6 ? fmt : (s == 3'h7 ? tst : 36'h0));
    if (t && tst[9])
      chk({35'h0, soc}, {35'h0, tst[8]});
  endtask
  task automatic rate(input int p);
    int n;
    logic c;
    cmd(ADDR_IO_FORMAT, 1'b0, {20'h0, 3'b011, 13'(p)});
    for (int k = 0; k < 3; k++)
    begin
      c = soc;
      n = 0;
      while (soc === c && n < 2000)
      begin
        @(negedge clk_sys);
        n++;
      end
      if (k > 0)
        chk(36'(n), 36'(p + 1));
      if (n >= 2000)
      begin
        num_errors++;
        $display("FAIL %0t output clock stopped", $time);
        stop_test();
      end
    end
  endtask
  initial
  begin
    rst = 1'b1;
    te = 1'b0;
    sel = 3'h6;
    {si, qn, inn, sn, ph, slot, fs} = 22'h0;
    fmt = IO_FORMAT_RESET;
    tst = TEST_RESET;
    void'($urandom(88));
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    for (int s = 0; s < 8; s++)
      dp(3'(s));
    for (int d = 0; d < 4; d++)
    begin
      cmd(ADDR_IO_FORMAT, d[0], {20'h0, 2'(d), 1'($urandom),
        13'(host.preload_for(3 + $urandom % 1699, 4))});
      repeat (4) dp(3'h6);
    end
    // Unmapped address and a short frame must leave both words alone.
    cmd(3'h5, 1'b1, 36'hFFFFFFFFF);
    host.send({3'h6, 1'b1, 36'h0}, 39);
    repeat (12) @(negedge clk_sys);
    dp(3'h6);
    dp(3'h7);
    te = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      cmd(ADDR_TEST, i[0], {22'h0, 1'($urandom), 2'(i % 3), 6'($urandom), 5'h0});
      repeat (4) dp(3'h7);
    end
    dp(3'h6);
    te = 1'b0;
    repeat (2) dp(3'h7);
    rate(PRELOAD_MAX);
    rate(PRELOAD_MIN);
    stop_test();
  end
endmodule
`default_nettype wire
